// File: rtl/srao_config.v
// line-rate and unsolicited-output configuration registers, two serial ports
// assumes an upstream parser presents decoded commands as one-cycle strobes
`timescale 1ns/10ps
`include "srao_map.vh"
module srao_config (
	// clock and reset
	input  wire        clk,
	input  wire        srst,
	// decoded command
	input  wire        cmd_valid,
	input  wire        cmd_write,
	input  wire [7:0]  cmd_reg,
	input  wire [31:0] cmd_value,
	input  wire        cmd_port_given,
	input  wire [7:0]  cmd_port,
	input  wire        cmd_arrival_port,
	// reply side
	input  wire        reply_sent,
	output reg         reply_valid,
	output reg         reply_error,
	output reg  [31:0] reply_value,
	output reg         reply_port_given,
	output reg  [7:0]  reply_port,
	// applied rates
	output reg  [31:0] line_rate_p1,
	output reg  [31:0] line_rate_p2,
	// unsolicited output
	input  wire [31:0] output_period_p1,
	input  wire [31:0] output_period_p2,
	input  wire        data_refresh,
	output reg  [31:0] output_code_p1,
	output reg  [31:0] output_code_p2,
	output reg         emit_p1,
	output reg         emit_p2,
	output reg  [39:0] emit_tag_p1,
	output reg  [39:0] emit_tag_p2
);

////////////////////////////////////////////////////////////////////////////////
function rate_ok;
	input [31:0] r;
	begin
		// anything outside this set is refused with an error reply
		case (r)
			`SRAO_RATE_9600,
			`SRAO_RATE_19200,
			`SRAO_RATE_38400,
			`SRAO_RATE_57600,
			`SRAO_RATE_115200,
			`SRAO_RATE_128000,
			`SRAO_RATE_230400,
			`SRAO_RATE_460800,
			`SRAO_RATE_921600: rate_ok = 1'b1;
			default: rate_ok = 1'b0;
		endcase
	end
endfunction

// five-char header per code, zero for code 0 and unknown codes
function [39:0] tag_of;
	input [31:0] c;
	begin
		case (c)
			`SRAO_CODE_ANGLES:    tag_of = `SRAO_ATTITUDE_ANGLES_TAG;
			`SRAO_CODE_QUAT:      tag_of = `SRAO_QUATERNION_TAG;
			`SRAO_CODE_QUAT_SENS: tag_of = `SRAO_QUAT_PLUS_SENSORS_TAG;
			`SRAO_CODE_COSINE:    tag_of = `SRAO_COSINE_MATRIX_TAG;
			`SRAO_CODE_MAGNETIC:  tag_of = `SRAO_MAGNETIC_TAG;
			`SRAO_CODE_ACCEL:     tag_of = `SRAO_ACCEL_TAG;
			`SRAO_CODE_RATE:      tag_of = `SRAO_RATE_TAG;
			`SRAO_CODE_THREE:     tag_of = `SRAO_THREE_SENSOR_TAG;
			`SRAO_CODE_ANG_SENS:  tag_of = `SRAO_ANGLES_PLUS_SENSORS_TAG;
			`SRAO_CODE_INERTIAL:  tag_of = `SRAO_INERTIAL_UNIT_TAG;
			`SRAO_CODE_BODY_ACC:  tag_of = `SRAO_BODY_ACCEL_TAG;
			`SRAO_CODE_INER_ACC:  tag_of = `SRAO_INERTIAL_ACCEL_TAG;
			`SRAO_CODE_SAT_GEO:   tag_of = `SRAO_SAT_GEODETIC_TAG;
			`SRAO_CODE_SAT_ECEF:  tag_of = `SRAO_SAT_EARTH_FIXED_TAG;
			`SRAO_CODE_NAV_GEO:   tag_of = `SRAO_NAV_GEODETIC_TAG;
			`SRAO_CODE_NAV_ECEF:  tag_of = `SRAO_NAV_EARTH_FIXED_TAG;
			`SRAO_CODE_DELTA:     tag_of = `SRAO_DELTA_INCREMENTS_TAG;
			default: tag_of = `SRAO_TAG_NONE;
		endcase
	end
endfunction

// one step of a pacing counter, resting at zero
function [31:0] pace_step;
	input [31:0] cnt;
	begin
		if (cnt == `SRAO_PACE_IDLE)
			pace_step = `SRAO_PACE_IDLE;
		else
			pace_step = cnt - `SRAO_PACE_STEP;
	end
endfunction

// reload one short of the period so emits come exactly a period apart
function [31:0] pace_load;
	input [31:0] period;
	begin
		if (period == `SRAO_PACE_IDLE)
			pace_load = `SRAO_PACE_IDLE;
		else
			pace_load = period - `SRAO_PACE_STEP;
	end
endfunction

// per-port value of the addressed port
function [31:0] pick;
	input        sel_two;
	input [31:0] one;
	input [31:0] two;
	begin
		if (sel_two)
			pick = two;
		else
			pick = one;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// command decode
wire       port_ok   = !cmd_port_given || cmd_port == `SRAO_PORT_ONE
                       || cmd_port == `SRAO_PORT_TWO;
wire       tgt_two   = cmd_port_given ? (cmd_port == `SRAO_PORT_TWO)
                       : cmd_arrival_port;
wire       is_rate   = cmd_reg == `SRAO_REG_LINE_RATE;
wire       is_sel    = cmd_reg == `SRAO_REG_OUT_SELECT;
wire       code_ok   = (cmd_value == `SRAO_CODE_OFF) || (tag_of(cmd_value) != `SRAO_TAG_NONE);
wire       val_ok    = is_rate ? rate_ok(cmd_value) : code_ok;
wire       cmd_ok    = (is_rate || is_sel) && port_ok && (!cmd_write || val_ok);
wire [31:0] rd_value = is_rate ? pick(tgt_two, line_rate_p1, line_rate_p2)
                       : pick(tgt_two, output_code_p1, output_code_p2);

// a command is taken only while no reply is outstanding
wire       take      = cmd_valid && !reply_valid && !pend_valid;
wire       sel_wr    = take && cmd_ok && cmd_write && is_sel;
// switch-off seen one cycle early so no message of the old type slips out
wire       off_p1    = sel_wr && !tgt_two && cmd_value == `SRAO_CODE_OFF;
wire       off_p2    = sel_wr && tgt_two && cmd_value == `SRAO_CODE_OFF;

// new rate waits here until the reply has gone out at the old rate
reg        pend_valid;
reg        pend_two;
reg [31:0] pend_rate;

always @(posedge clk) begin
	if (srst) begin
		reply_valid      <= 1'b0;
		reply_error      <= 1'b0;
		reply_value      <= 32'h00000000;
		reply_port_given <= 1'b0;
		reply_port       <= 8'h00;
		line_rate_p1     <= `SRAO_RATE_RESET;
		line_rate_p2     <= `SRAO_RATE_RESET;
		output_code_p1   <= `SRAO_CODE_RESET;
		output_code_p2   <= `SRAO_CODE_RESET;
		pend_valid       <= 1'b0;
		pend_two         <= 1'b0;
		pend_rate        <= `SRAO_RATE_RESET;
	end else begin
		if (reply_sent) begin
			reply_valid <= 1'b0;
			if (pend_valid) begin
				pend_valid <= 1'b0;
				if (pend_two)
					line_rate_p2 <= pend_rate;
				else
					line_rate_p1 <= pend_rate;
			end
		end
		// a new command is taken only while no reply is outstanding
		if (take) begin
			reply_valid      <= 1'b1;
			reply_error      <= !cmd_ok;
			reply_port_given <= cmd_port_given;
			reply_port       <= cmd_port_given ? cmd_port : 8'h00;
			reply_value      <= cmd_write ? cmd_value : rd_value;
			if (cmd_ok && cmd_write && is_rate) begin
				pend_valid <= 1'b1;
				pend_two   <= tgt_two;
				pend_rate  <= cmd_value;
			end
			if (cmd_ok && cmd_write && is_sel) begin
				if (tgt_two)
					output_code_p2 <= cmd_value;
				else
					output_code_p1 <= cmd_value;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// pacing: a refresh arms the port, the period counter releases it
reg [31:0] pace_p1;
reg [31:0] pace_p2;
reg        armed_p1;
reg        armed_p2;

always @(posedge clk) begin
	if (srst) begin
		pace_p1     <= 32'h00000000;
		pace_p2     <= 32'h00000000;
		armed_p1    <= 1'b0;
		armed_p2    <= 1'b0;
		emit_p1     <= 1'b0;
		emit_p2     <= 1'b0;
		emit_tag_p1 <= 40'h0000000000;
		emit_tag_p2 <= 40'h0000000000;
	end else begin
		emit_p1 <= 1'b0;
		emit_p2 <= 1'b0;
		pace_p1 <= pace_step(pace_p1);
		pace_p2 <= pace_step(pace_p2);
		if (data_refresh && output_code_p1 != `SRAO_CODE_OFF) armed_p1 <= 1'b1;
		if (data_refresh && output_code_p2 != `SRAO_CODE_OFF) armed_p2 <= 1'b1;
		// port one: a refresh in the emit cycle re-arms, so the set wins
		if (output_code_p1 == `SRAO_CODE_OFF || off_p1) armed_p1 <= 1'b0;
		else if (armed_p1 && pace_p1 == `SRAO_PACE_IDLE) begin
			armed_p1    <= data_refresh;
			emit_p1     <= 1'b1;
			emit_tag_p1 <= tag_of(output_code_p1);
			pace_p1     <= pace_load(output_period_p1);
		end
		// port two: same pacing on its own counter
		if (output_code_p2 == `SRAO_CODE_OFF || off_p2) armed_p2 <= 1'b0;
		else if (armed_p2 && pace_p2 == `SRAO_PACE_IDLE) begin
			armed_p2    <= data_refresh;
			emit_p2     <= 1'b1;
			emit_tag_p2 <= tag_of(output_code_p2);
			pace_p2     <= pace_load(output_period_p2);
		end
	end
end

endmodule // srao_config

// File: rtl/srao_map.vh
// register map and constants for the line-rate / unsolicited-output block
// assumes a command parser upstream that decodes register writes and reads
//
// Operation
// - reply at old rate, then switch rate
// - optional port byte, 1 or 2
// - no port byte: use arrival port
// - echo port byte only if supplied
// - output code with optional port byte
// - code zero sends nothing unsolicited
// - nonzero code emits on each refresh (code: refreshes inside one pacing period give a single emit)
// - pace at output frequency setting
// - orientation codes 1,2,8,9 mapped
// - sensor codes 10-14,19 mapped
// - codes 16,17,20-23,30 mapped
// - message starts with code's tag
`ifndef SRAO_MAP_VH
`define SRAO_MAP_VH
`define SRAO_REG_LINE_RATE   8'h05
`define SRAO_REG_OUT_SELECT  8'h06
`define SRAO_PORT_ONE        8'h01
`define SRAO_PORT_TWO        8'h02
`define SRAO_RATE_RESET      32'h0001C200
`define SRAO_CODE_RESET      32'h00000000
`define SRAO_DIV_RESET       32'h00000001
// pacing counter rest value and step
`define SRAO_PACE_IDLE       32'h00000000
`define SRAO_PACE_STEP       32'h00000001
// accepted line rates
`define SRAO_RATE_9600       32'h00002580
`define SRAO_RATE_19200      32'h00004B00
`define SRAO_RATE_38400      32'h00009600
`define SRAO_RATE_57600      32'h0000E100
`define SRAO_RATE_115200     32'h0001C200
`define SRAO_RATE_128000     32'h0001F400
`define SRAO_RATE_230400     32'h00038400
`define SRAO_RATE_460800     32'h00070800
`define SRAO_RATE_921600     32'h000E1000
// unsolicited output selection codes
`define SRAO_CODE_OFF        32'h00000000
`define SRAO_CODE_ANGLES     32'h00000001
`define SRAO_CODE_QUAT       32'h00000002
`define SRAO_CODE_QUAT_SENS  32'h00000008
`define SRAO_CODE_COSINE     32'h00000009
`define SRAO_CODE_MAGNETIC   32'h0000000A
`define SRAO_CODE_ACCEL      32'h0000000B
`define SRAO_CODE_RATE       32'h0000000C
`define SRAO_CODE_THREE      32'h0000000D
`define SRAO_CODE_ANG_SENS   32'h0000000E
`define SRAO_CODE_BODY_ACC   32'h00000010
`define SRAO_CODE_INER_ACC   32'h00000011
`define SRAO_CODE_INERTIAL   32'h00000013
`define SRAO_CODE_SAT_GEO    32'h00000014
`define SRAO_CODE_SAT_ECEF   32'h00000015
`define SRAO_CODE_NAV_GEO    32'h00000016
`define SRAO_CODE_NAV_ECEF   32'h00000017
`define SRAO_CODE_DELTA      32'h0000001E
// five ASCII header characters per code, first character in the top byte
`define SRAO_TAG_NONE                40'h0000000000
`define SRAO_ATTITUDE_ANGLES_TAG     40'h564E595052
`define SRAO_QUATERNION_TAG          40'h564E51544E
`define SRAO_QUAT_PLUS_SENSORS_TAG   40'h564E514D52
`define SRAO_COSINE_MATRIX_TAG       40'h564E44434D
`define SRAO_MAGNETIC_TAG            40'h564E4D4147
`define SRAO_ACCEL_TAG               40'h564E414343
`define SRAO_RATE_TAG                40'h564E475952
`define SRAO_THREE_SENSOR_TAG        40'h564E4D4152
`define SRAO_ANGLES_PLUS_SENSORS_TAG 40'h564E594D52
`define SRAO_BODY_ACCEL_TAG          40'h564E594241
`define SRAO_INERTIAL_ACCEL_TAG      40'h564E594941
`define SRAO_INERTIAL_UNIT_TAG       40'h564E494D55
`define SRAO_SAT_GEODETIC_TAG        40'h564E475053
`define SRAO_SAT_EARTH_FIXED_TAG     40'h564E475045
`define SRAO_NAV_GEODETIC_TAG        40'h564E494E53
`define SRAO_NAV_EARTH_FIXED_TAG     40'h564E494E45
`define SRAO_DELTA_INCREMENTS_TAG    40'h564E445456
`endif

// File: testbench/srao_host.sv
// host model: hands reply_sent back once per reply after dly cycles
// assumes reply_valid holds until reply_sent
`timescale 1ns/10ps
module srao_host (
	input  wire       clk,
	input  wire       reply_valid,
	input  wire [3:0] dly,
	output reg        reply_sent
);
	reg [3:0] n = 4'h0;
	reg       done = 1'b0;
	initial reply_sent = 1'b0;
	// no new command until the reply is out and the port retuned
	always @(posedge clk) begin
		reply_sent <= 1'b0;
		if (!reply_valid) begin
			n <= 4'h0;
			done <= 1'b0;
		end else if (!done) begin
			n <= n + 4'h1;
			if (n == dly) begin
				reply_sent <= 1'b1;
				done <= 1'b1;
			end
		end
	end
endmodule // srao_host

// File: testbench/srao_config_chk.sv
// port checker for the configuration block
// assumes it is bound onto srao_config
`timescale 1ns/10ps
module srao_config_chk (
	input wire        clk, srst, cmd_valid, cmd_port_given, reply_sent,
	input wire        reply_valid, reply_error, reply_port_given, emit_p1,
	input wire        emit_p2,
	input wire [31:0] reply_value, line_rate_p1, line_rate_p2,
	input wire [31:0] output_code_p1, output_code_p2
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_rate_hold: assert property (reply_valid && !reply_sent |=> $stable(line_rate_p1))
		else $error("rate moved before reply left");
	a_rate_cause: assert property ($changed(line_rate_p2) && !$past(srst) |-> $past(reply_sent))
		else $error("rate changed without reply sent");
	a_rate_legal: assert property (line_rate_p1 inside {9600, 19200, 38400, 57600, 115200,
		128000, 230400, 460800, 921600}) else $error("illegal rate applied");
	a_port_echo: assert property ($rose(reply_valid) && !reply_error |->
		reply_port_given == $past(cmd_port_given)) else $error("port echo wrong");
	a_quiet_one: assert property (output_code_p1 == 0 |-> !emit_p1) else $error("p1 not quiet");
	a_quiet_two: assert property (output_code_p2 == 0 |-> !emit_p2) else $error("p2 not quiet");
	a_err_keep: assert property ($rose(reply_valid) && reply_error |-> $stable(output_code_p1)
		&& $stable(output_code_p2)) else $error("error reply changed state");
	a_reply_hold: assert property (reply_valid && !reply_sent |=> reply_valid && $stable(reply_value))
		else $error("reply dropped early");
	a_emit_pulse: assert property (emit_p1 |=> !emit_p1) else $error("emit too long");
endmodule // srao_config_chk
bind srao_config srao_config_chk srao_config_chk_inst (.clk(clk), .srst(srst),
	.cmd_valid(cmd_valid), .cmd_port_given(cmd_port_given), .reply_sent(reply_sent),
	.reply_valid(reply_valid), .reply_error(reply_error), .reply_port_given(reply_port_given),
	.emit_p1(emit_p1), .emit_p2(emit_p2), .reply_value(reply_value),
	.line_rate_p1(line_rate_p1), .line_rate_p2(line_rate_p2),
	.output_code_p1(output_code_p1), .output_code_p2(output_code_p2));

// File: testbench/testbench.sv
// self-checking bench for srao_config with the host model
// assumes rates and codes reset to 115200 and 0
`timescale 1ns/10ps
`include "srao_map.vh"
module testbench;
	reg        clk, srst, cmd_valid, cmd_write, cmd_port_given, cmd_arrival_port, data_refresh;
	reg [7:0]  cmd_reg, cmd_port;
	reg [31:0] cmd_value, output_period_p1, output_period_p2, r1, r2, c1, c2;
	reg [3:0]  dly;
	reg        t;
	wire       reply_sent, reply_valid, reply_error, reply_port_given, emit_p1, emit_p2;
	wire [7:0] reply_port;
	wire [31:0] reply_value, line_rate_p1, line_rate_p2, output_code_p1, output_code_p2;
	wire [39:0] emit_tag_p1, emit_tag_p2;
	int        miscompares = 0, check_count = 0, i, k;
	typedef struct packed {logic w; logic [7:0] rg; logic [31:0] v;
		logic pg; logic [7:0] p; logic a, er;} srao_row_t;
	srao_row_t rows [8] = '{'{1, 8'h05, 32'h2580, 0, 8'h00, 0, 0}, '{1, 8'h05, 32'hE1000, 1, 8'h02, 0, 0},
		'{1, 8'h05, 32'h3039, 0, 8'h00, 1, 1}, '{1, 8'h06, 32'h8, 1, 8'h01, 1, 0},
		'{1, 8'h06, 32'hE, 0, 8'h00, 1, 0}, '{1, 8'h06, 32'h5, 0, 8'h00, 0, 1},
		'{1, 8'h05, 32'h9600, 1, 8'h03, 0, 1}, '{0, 8'h06, 32'h0, 1, 8'h02, 0, 0}};
	srao_config srao_config_inst (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_reg(cmd_reg), .cmd_value(cmd_value),
		.cmd_port_given(cmd_port_given), .cmd_port(cmd_port),
		.cmd_arrival_port(cmd_arrival_port), .reply_sent(reply_sent), .reply_valid(reply_valid),
		.reply_error(reply_error), .reply_value(reply_value), .reply_port_given(reply_port_given),
		.reply_port(reply_port), .line_rate_p1(line_rate_p1), .line_rate_p2(line_rate_p2),
		.output_period_p1(output_period_p1), .output_period_p2(output_period_p2),
		.data_refresh(data_refresh), .output_code_p1(output_code_p1),
		.output_code_p2(output_code_p2), .emit_p1(emit_p1), .emit_p2(emit_p2),
		.emit_tag_p1(emit_tag_p1), .emit_tag_p2(emit_tag_p2));
	srao_host srao_host_inst (.clk(clk), .reply_valid(reply_valid), .dly(dly), .reply_sent(reply_sent));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input [127:0] s, input [127:0] e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("Error t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one command, checks reply and the state left behind
	task automatic xfer(input srao_row_t q);
		@(posedge clk);
		{cmd_valid, cmd_write, cmd_reg, cmd_value} <= {1'b1, q.w, q.rg, q.v};
		{cmd_port_given, cmd_port, cmd_arrival_port} <= {q.pg, q.p, q.a};
		@(posedge clk) cmd_valid <= 1'b0;
		#1;
		t = q.pg ? (q.p == 8'h02) : q.a;
		chk(reply_error, q.er);
		if (!q.er) chk({reply_port_given, reply_port, reply_value},
			{q.pg, q.pg ? q.p : 8'h00, q.w ? q.v : t ? c2 : c1});
		for (k = 0; k < 30 && reply_valid === 1'b1; k++) @(posedge clk) #1;
		if (q.w && !q.er && q.rg == 8'h05) if (t) r2 = q.v; else r1 = q.v;
		if (q.w && !q.er && q.rg == 8'h06) if (t) c2 = q.v; else c1 = q.v;
		chk({line_rate_p1, line_rate_p2, output_code_p1, output_code_p2}, {r1, r2, c1, c2});
	endtask
	initial begin
		{srst, cmd_valid, cmd_write, cmd_port_given, cmd_arrival_port, data_refresh} = 6'h20;
		{cmd_reg, cmd_port, cmd_value, dly} = 52'h0;
		output_period_p1 = 32'h4;
		output_period_p2 = 32'h4;
		{r1, r2, c1, c2} = {32'h1C200, 32'h1C200, 64'h0};
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		#1 chk({line_rate_p1, line_rate_p2, output_code_p1, output_code_p2}, {r1, r2, c1, c2});
		for (i = 0; i < 8; i++) begin
			@(posedge clk) dly <= 4'(i);
			xfer(rows[i]);
		end
		// a fresh reading must be emitted on each of the two ports selected above
		@(posedge clk) data_refresh <= 1'b1;
		@(posedge clk) data_refresh <= 1'b0;
		for (k = 0; k < 50 && emit_p1 !== 1'b1; k++) @(posedge clk) #1;
		chk(emit_p1, 1'b1);
		chk(emit_tag_p1, `SRAO_QUAT_PLUS_SENSORS_TAG);
		chk({emit_p2, emit_tag_p2}, {1'b1, `SRAO_ANGLES_PLUS_SENSORS_TAG});
		xfer('{1, 8'h06, 32'h0, 1, 8'h01, 0, 0});
		@(posedge clk) data_refresh <= 1'b1;
		@(posedge clk) data_refresh <= 1'b0;
		t = 1'b0;
		repeat (20) @(posedge clk) #1 t = t | emit_p1;
		chk(t, 1'b0);
		// steady refreshes: port two emits exactly one period apart
		@(posedge clk) data_refresh <= 1'b1;
		for (k = 0; k < 50 && emit_p2 !== 1'b1; k++) @(posedge clk) #1;
		for (k = 1; k < 50; k++) begin
			@(posedge clk) #1;
			if (emit_p2 === 1'b1) break;
		end
		chk(k, output_period_p2);
		@(posedge clk) data_refresh <= 1'b0;
		// reset again in mid-run: rates, codes, reply_valid and emit_p2 back to reset values
		@(posedge clk) srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		#1 chk({line_rate_p1, line_rate_p2, output_code_p1, output_code_p2, reply_valid, emit_p2},
			{`SRAO_RATE_RESET, `SRAO_RATE_RESET, 64'h0, 2'b00});
		wrap_up;
	end
	// watchdog: far above the hundred-odd cycles the tests need
	initial begin
		#1000000;
		miscompares++;
		wrap_up;
	end
endmodule // testbench
